// ===== rtl/lau_pkg.sv
// Purpose: Shared constants and carriers of the load address unit.
// Assumes: 32-bit instruction words and data; AHB-Lite register access.
// Notes:   Instruction field positions, load codes and register offsets live here.
package lau_pkg;

  // Instruction fields shared by both load forms.
  localparam int unsigned DST_LSB   = 23;
  localparam int unsigned Y_BIT     = 7;
  localparam int unsigned LDST_LSB  = 4;
  localparam int unsigned S_BIT     = 1;
  localparam int unsigned FORM_LSB  = 2;
  localparam logic [1:0]  FORM_SHORT = 2'h1;
  localparam logic [1:0]  FORM_LONG  = 2'h3;
  // Short form fields.
  localparam int unsigned BASE_LSB  = 18;
  localparam int unsigned OFS_LSB   = 13;
  localparam int unsigned MODE_LSB  = 9;
  localparam int unsigned MODE_MOD  = 3;
  localparam int unsigned MODE_REG  = 2;
  localparam int unsigned MODE_POST = 1;
  localparam int unsigned MODE_ADD  = 0;
  // Long form constant.
  localparam int unsigned LIMM_LSB  = 8;
  localparam int unsigned LIMM_W    = 15;

  // Access type codes.
  localparam logic [2:0] SIGNED_BYTE_LOAD       = 3'h2;
  localparam logic [2:0] UNSIGNED_BYTE_LOAD     = 3'h1;
  localparam logic [2:0] SIGNED_HALFWORD_LOAD   = 3'h4;
  localparam logic [2:0] UNSIGNED_HALFWORD_LOAD = 3'h0;
  localparam logic [2:0] WORD_LOAD              = 3'h6;

  // Base registers that may address circularly are 4 to 7 of each file.
  localparam logic [2:0] CIRC_IDX_HI = 3'h1;
  localparam logic [1:0] AM_CIRC_BK0 = 2'h1;
  localparam logic [1:0] AM_CIRC_BK1 = 2'h2;
  localparam int unsigned AM_BK0_LSB = 16;
  localparam int unsigned AM_BK1_LSB = 21;
  localparam logic [31:0] AM_RST     = 32'h0000_0000;
  localparam logic [31:0] AM_MASK    = 32'h03FF_FFFF;

  // Register map, byte addresses.
  localparam logic [7:0] OFS_ADDR_MODE = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_LAST_ADDR = 8'h08;
  localparam int unsigned ST_OCC_LSB   = 16;
  localparam int unsigned ST_MISALIGN  = 24;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic        unit;
    logic [1:0]  size;
    logic [31:0] addr;
  } lau_mem_req_t;

  typedef struct packed {
    logic        side;
    logic [4:0]  idx;
    logic [31:0] data;
  } lau_wb_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] ldst;
    logic [1:0] lane;
    logic       side;
    logic [4:0] idx;
  } lau_stage_t;

endpackage : lau_pkg

// ===== rtl/lau_load_unit.sv
// Purpose: Decode and execute memory loads, short and long forms.
// Assumes: Dispatch raises instr_valid only for instructions whose condition holds.
// Notes:   Memory data is sampled four cycles after the request is presented.
//
// Functional notes
// - Short address: base plus register or constant
// - Side bit picks data unit and file
// - Short offset shifted by access size
// - Mode picks add or subtract offset
// - Offset and pre modes access computed address
// - Post modes access old base, write back
// - Circular arithmetic for registers four to seven
// - Narrow loads fill low destination bits
// - Signed narrow loads copy the sign bit
// - Unsigned narrow loads clear upper bits
// - Word loads write all 32 bits
// - Destination file from its own select bit
// - Four-bit mode field decoded bit by bit
// - Long form base from page registers
// - Long form runs on second data unit
// - Long form only adds, never modifies base
// - Long form always linear
// - Long constant shifted by access size
`timescale 1ns/1ns
`default_nettype none

module lau_load_unit #(
  parameter int unsigned STAGES = 4
) (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // Register bus
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Dispatch
  input  wire logic                  instr_valid,
  input  wire logic [31:0]           instr,
  // Register file reads
  output logic                       rf_rd_side,
  output logic [4:0]                 rf_base_idx,
  output logic [4:0]                 rf_index_idx,
  input  wire logic [31:0]           rf_base_data,
  input  wire logic [31:0]           rf_index_data,
  input  wire logic [31:0]           page_base_a,
  input  wire logic [31:0]           page_base_b,
  // Register file writes
  output logic                       base_wb_valid,
  output lau_pkg::lau_wb_t           base_wb,
  output logic                       dst_we,
  output lau_pkg::lau_wb_t           dst_wb,
  // Data memory
  output logic                       mem_req_valid,
  output lau_pkg::lau_mem_req_t      mem_req,
  input  wire logic [31:0]           mem_rdata
);

  logic [2:0]  ldst;
  logic [1:0]  form;
  logic        is_load;
  logic        accept;
  logic        long_form;
  logic [3:0]  mode;
  logic [1:0]  scale;
  logic [31:0] ofs_raw;
  logic [31:0] ofs_scaled;
  logic [31:0] base_val;
  logic        circ_en;
  logic [4:0]  blk_size;
  logic [1:0]  am_field;
  logic [31:0] calc_addr;
  logic [31:0] access_addr;
  logic        misaligned;
  logic [31:0] amc_r;
  logic [15:0] load_cnt_r;
  logic        misalign_r;
  logic [31:0] last_addr_r;
  lau_pkg::lau_stage_t stg_r [STAGES];

  // Wrap inside a power-of-two block when circular, else plain linear result.
  function automatic logic [31:0] addr_calc(input logic [31:0] base, input logic [31:0] ofs,
                                            input logic sub, input logic circ,
                                            input logic [4:0] bk);
    logic [31:0] sum;
    logic [32:0] span;
    logic [31:0] mask;
    sum  = sub ? base - ofs : base + ofs;
    span = 33'h0_0000_0001 << ({1'b0, bk} + 6'h01);
    mask = 32'(span - 33'h0_0000_0001);
    addr_calc = circ ? ((base & ~mask) | (sum & mask)) : sum;
  endfunction : addr_calc

  assign ldst      = instr[lau_pkg::LDST_LSB +: 3];
  assign form      = instr[lau_pkg::FORM_LSB +: 2];
  assign mode      = instr[lau_pkg::MODE_LSB +: 4];
  assign is_load   = (ldst != 3'h3) && (ldst != 3'h5) && (ldst != 3'h7) &&
                     ((form == lau_pkg::FORM_SHORT) || (form == lau_pkg::FORM_LONG));
  assign accept    = instr_valid && is_load;
  assign long_form = (form == lau_pkg::FORM_LONG);

  // Register file addressing follows the unit side; callers keep base and index together.
  assign rf_rd_side   = instr[lau_pkg::Y_BIT];
  assign rf_base_idx  = instr[lau_pkg::BASE_LSB +: 5];
  assign rf_index_idx = instr[lau_pkg::OFS_LSB +: 5];

  always_comb begin
    if (ldst == lau_pkg::WORD_LOAD) begin
      scale = 2'h2;
    end else if ((ldst == lau_pkg::SIGNED_HALFWORD_LOAD) ||
                 (ldst == lau_pkg::UNSIGNED_HALFWORD_LOAD)) begin
      scale = 2'h1;
    end else begin
      scale = 2'h0;
    end
  end

  always_comb begin
    if (long_form) begin
      ofs_raw  = {17'h0_0000, instr[lau_pkg::LIMM_LSB +: lau_pkg::LIMM_W]};
      base_val = instr[lau_pkg::Y_BIT] ? page_base_b : page_base_a;
    end else if (mode[lau_pkg::MODE_REG]) begin
      ofs_raw  = rf_index_data;
      base_val = rf_base_data;
    end else begin
      ofs_raw  = {27'h000_0000, instr[lau_pkg::OFS_LSB +: 5]};
      base_val = rf_base_data;
    end
  end

  assign ofs_scaled = ofs_raw << scale;

  // Only short-form bases 4 to 7 consult the mode control register.
  assign am_field = amc_r[{instr[lau_pkg::Y_BIT], rf_base_idx[1:0], 1'b0} +: 2];
  assign circ_en  = !long_form && (rf_base_idx[4:2] == lau_pkg::CIRC_IDX_HI) &&
                    ((am_field == lau_pkg::AM_CIRC_BK0) ||
                     (am_field == lau_pkg::AM_CIRC_BK1));
  assign blk_size = (am_field == lau_pkg::AM_CIRC_BK1) ? amc_r[lau_pkg::AM_BK1_LSB +: 5]
                                                        : amc_r[lau_pkg::AM_BK0_LSB +: 5];

  // Long form always adds; short form subtracts when the add bit is clear.
  assign calc_addr = addr_calc(base_val, ofs_scaled,
                               !long_form && !mode[lau_pkg::MODE_ADD],
                               circ_en, blk_size);

  assign access_addr = (!long_form && mode[lau_pkg::MODE_MOD] && mode[lau_pkg::MODE_POST])
                       ? base_val : calc_addr;

  assign misaligned = ((scale == 2'h2) && (access_addr[1:0] != 2'h0)) ||
                      ((scale == 2'h1) && access_addr[0]);

  // First execute stage: memory request.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req_valid <= 1'b0;
      mem_req       <= '0;
    end else begin
      mem_req_valid <= accept;
      if (accept) begin
        mem_req.addr <= access_addr;
        mem_req.size <= scale;
        mem_req.unit <= long_form | instr[lau_pkg::Y_BIT];
      end
    end
  end

  // First execute stage: base update for modifying short-form modes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_wb_valid <= 1'b0;
      base_wb       <= '0;
    end else begin
      base_wb_valid <= accept && !long_form && mode[lau_pkg::MODE_MOD];
      if (accept && !long_form) begin
        base_wb.side <= instr[lau_pkg::Y_BIT];
        base_wb.idx  <= rf_base_idx;
        base_wb.data <= calc_addr;
      end
    end
  end

  // Pipeline carrying destination and lane information to the fifth stage.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stg_r[0] <= '0;
    end else begin
      stg_r[0].valid <= accept;
      stg_r[0].ldst  <= ldst;
      stg_r[0].lane  <= access_addr[1:0];
      stg_r[0].side  <= instr[lau_pkg::S_BIT];
      stg_r[0].idx   <= instr[lau_pkg::DST_LSB +: 5];
    end
  end

  for (genvar g = 1; g < STAGES; g++) begin : g_stage
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stg_r[g] <= '0;
      end else begin
        stg_r[g] <= stg_r[g-1];
      end
    end
  end

  // Fifth execute stage: lane select and extension of the memory word.
  logic [7:0]  byte_sel;
  logic [15:0] half_sel;
  assign byte_sel = mem_rdata[{stg_r[STAGES-1].lane, 3'h0} +: 8];
  assign half_sel = mem_rdata[{stg_r[STAGES-1].lane[1], 4'h0} +: 16];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dst_we <= 1'b0;
      dst_wb <= '0;
    end else begin
      dst_we <= stg_r[STAGES-1].valid;
      if (stg_r[STAGES-1].valid) begin
        dst_wb.side <= stg_r[STAGES-1].side;
        dst_wb.idx  <= stg_r[STAGES-1].idx;
        case (stg_r[STAGES-1].ldst)
          lau_pkg::SIGNED_BYTE_LOAD:       dst_wb.data <= {{24{byte_sel[7]}}, byte_sel};
          lau_pkg::UNSIGNED_BYTE_LOAD:     dst_wb.data <= {24'h00_0000, byte_sel};
          lau_pkg::SIGNED_HALFWORD_LOAD:   dst_wb.data <= {{16{half_sel[15]}}, half_sel};
          lau_pkg::UNSIGNED_HALFWORD_LOAD: dst_wb.data <= {16'h0000, half_sel};
          default:                         dst_wb.data <= mem_rdata;
        endcase
      end
    end
  end

  // Register bus: zero wait states, always OKAY.
  logic        bus_wr_r;
  logic [7:0]  bus_addr_r;
  logic        bus_take;
  logic [31:0] occ_bits;
  assign bus_take  = hsel && hready && (htrans == lau_pkg::HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    occ_bits = '0;
    for (int i = 0; i < STAGES; i++) begin
      occ_bits[lau_pkg::ST_OCC_LSB + i] = stg_r[i].valid;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wr_r   <= 1'b0;
      bus_addr_r <= 8'h00;
    end else begin
      bus_wr_r   <= bus_take && hwrite;
      bus_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_take && !hwrite) begin
      if (haddr[7:0] == lau_pkg::OFS_ADDR_MODE) begin
        hrdata <= amc_r;
      end else if (haddr[7:0] == lau_pkg::OFS_STATUS) begin
        hrdata <= {7'h00, misalign_r, 8'h00, load_cnt_r} | occ_bits;
      end else if (haddr[7:0] == lau_pkg::OFS_LAST_ADDR) begin
        hrdata <= last_addr_r;
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      amc_r <= lau_pkg::AM_RST;
    end else if (bus_wr_r && (bus_addr_r == lau_pkg::OFS_ADDR_MODE)) begin
      amc_r <= hwdata & lau_pkg::AM_MASK;
    end
  end

  // Status: load count, last address and a sticky misalignment flag (set wins).
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_cnt_r  <= 16'h0000;
      last_addr_r <= 32'h0000_0000;
      misalign_r  <= 1'b0;
    end else begin
      if (accept) begin
        load_cnt_r  <= load_cnt_r + 16'h0001;
        last_addr_r <= access_addr;
      end
      if (accept && misaligned) begin
        misalign_r <= 1'b1;
      end else if (bus_wr_r && (bus_addr_r == lau_pkg::OFS_STATUS) &&
                   hwdata[lau_pkg::ST_MISALIGN]) begin
        misalign_r <= 1'b0;
      end
    end
  end

  // Checks.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic short_acc;
  assign short_acc = accept && !long_form;

  // Accept edge k fills stage 0; the last stage feeds the write register at edge k+4.
  dst_delay_a: assert property (accept |-> ##5 dst_we)
    else $error("destination write not after four delay slots");
  base_upd_a: assert property (short_acc && mode[lau_pkg::MODE_MOD] |=> base_wb_valid)
    else $error("modifying mode did not update the base");
  long_nomod_a: assert property (accept && long_form |=> !base_wb_valid)
    else $error("long form modified a base register");
  long_unit_a: assert property (accept && long_form |=> mem_req.unit)
    else $error("long form not on the second data unit");
  post_addr_a: assert property (short_acc && mode[lau_pkg::MODE_MOD] &&
                                mode[lau_pkg::MODE_POST]
                                |=> mem_req.addr == $past(rf_base_data))
    else $error("post mode did not access the old base");
  lin_offset_a: assert property (short_acc && !circ_en && !mode[lau_pkg::MODE_MOD] &&
                                 mode[lau_pkg::MODE_REG] && mode[lau_pkg::MODE_ADD]
                                 |=> mem_req.addr ==
                                     $past(rf_base_data) + ($past(rf_index_data) << $past(scale)))
    else $error("positive register offset address wrong");
  long_addr_a: assert property (accept && long_form && (ldst == lau_pkg::WORD_LOAD)
                                |=> mem_req.addr[1:0] == $past(base_val[1:0]))
    else $error("long word offset not scaled by four");
  dst_file_a: assert property (accept |-> ##5 dst_wb.side == $past(instr[lau_pkg::S_BIT], 5))
    else $error("destination file select wrong");
  zext_byte_a: assert property (dst_we && ($past(stg_r[STAGES-1].ldst) ==
                                lau_pkg::UNSIGNED_BYTE_LOAD) |-> dst_wb.data[31:8] == 24'h00_0000)
    else $error("unsigned byte not zero filled");
  sext_byte_a: assert property (dst_we && ($past(stg_r[STAGES-1].ldst) ==
                                lau_pkg::SIGNED_BYTE_LOAD) |-> dst_wb.data[31:8] ==
                                {24{dst_wb.data[7]}})
    else $error("signed byte not sign extended");
  word_full_a: assert property (dst_we && ($past(stg_r[STAGES-1].ldst) == lau_pkg::WORD_LOAD)
                                |-> dst_wb.data == $past(mem_rdata))
    else $error("word load altered the data");
  half_zext_a: assert property (dst_we && ($past(stg_r[STAGES-1].ldst) ==
                                lau_pkg::UNSIGNED_HALFWORD_LOAD)
                                |-> dst_wb.data[31:16] == 16'h0000)
    else $error("unsigned halfword not zero filled");
  misalign_set_a: assert property (accept && misaligned |=> misalign_r)
    else $error("misaligned access not recorded");
  pre_wb_a: assert property (short_acc && mode[lau_pkg::MODE_MOD] &&
                             !mode[lau_pkg::MODE_POST] |=> base_wb.data == mem_req.addr)
    else $error("pre mode address differs from written base");

  // Main scenarios: post increment, long form, pre decrement, circular and misaligned.
  post_inc_c: cover property (short_acc && mode == 4'hF ##5 dst_we);
  long_load_c: cover property (accept && long_form ##5 dst_we);
  pre_dec_c: cover property (short_acc && mode == 4'hC ##5 dst_we);
  circ_use_c: cover property (accept && circ_en);
  misalign_c: cover property (accept && misaligned);

endmodule : lau_load_unit

`default_nettype wire

// ===== verif/lau_partner.sv
// Purpose: Register files and data memory beside the load unit.
// Assumes: Memory data must stand in the third cycle after a request.
// Notes:   Outside that cycle the read data is a pattern that changes every cycle.
`timescale 1ns/1ns
`default_nettype none
module lau_partner (
  // Clock
  input  wire logic                  hclk,
  // Register file reads
  input  wire logic                  rf_rd_side,
  input  wire logic [4:0]            rf_base_idx,
  input  wire logic [4:0]            rf_index_idx,
  output logic [31:0]                rf_base_data,
  output logic [31:0]                rf_index_data,
  output logic [31:0]                page_base_a,
  output logic [31:0]                page_base_b,
  // Data memory
  input  wire logic                  mem_req_valid,
  input  wire lau_pkg::lau_mem_req_t mem_req,
  output logic [31:0]                mem_rdata
);
  logic [31:0] rf [2][32];
  logic [31:0] pg [2];
  logic [31:0] ap [3];
  logic [2:0]  vld = 3'h0;
  logic        tog = 1'b0;

  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[31:2], 2'b01} * 32'h9E37_79B9;
  endfunction : mem_word

  // Writes land after the edge, so a read sampled at that edge still sees the old value.
  task automatic set_reg(input logic s, input logic [4:0] i, input logic [31:0] v);
    rf[s][i] <= v;
  endtask : set_reg

  task automatic set_pg(input logic s, input logic [31:0] v);
    pg[s] <= v;
  endtask : set_pg

  assign rf_base_data  = rf[rf_rd_side][rf_base_idx];
  assign rf_index_data = rf[rf_rd_side][rf_index_idx];
  assign page_base_a   = pg[0];
  assign page_base_b   = pg[1];
  assign mem_rdata     = vld[2] ? mem_word(ap[2]) : ~mem_word(ap[2]) ^ {32{tog}};

  always_ff @(posedge hclk) begin
    vld <= {vld[1:0], mem_req_valid};
    ap  <= '{mem_req.addr, ap[0], ap[1]};
    tog <= ~tog;
  end
endmodule : lau_partner
`default_nettype wire

// ===== verif/load_address_unit_bench.sv
// Purpose: Self-checking bench of the load unit with random instruction streams.
// Assumes: Zero-wait register bus; the partner answers memory reads.
// Notes:   Expected pulses are queued with the edge at which they must be seen.
`timescale 1ns/1ns
`default_nettype none
module load_address_unit_bench;
  typedef struct packed {
    int          c;
    logic [37:0] v;
  } lau_exp_t;

  logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp, instr_valid;
  logic                  rf_rd_side, base_wb_valid, dst_we, mem_req_valid;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [4:0]            rf_base_idx, rf_index_idx;
  logic [31:0]           haddr, hwdata, hrdata, instr, rf_base_data, rf_index_data;
  logic [31:0]           page_base_a, page_base_b, mem_rdata, last_a, am, rd;
  lau_pkg::lau_wb_t      base_wb, dst_wb;
  lau_pkg::lau_mem_req_t mem_req;
  lau_exp_t              eq_mem [$], eq_bwb [$], eq_dst [$];
  int                    cyc, n_mismatch, compares, n_loads;
  logic [2:0]            codes [7] = '{lau_pkg::SIGNED_BYTE_LOAD, lau_pkg::UNSIGNED_BYTE_LOAD,
    lau_pkg::SIGNED_HALFWORD_LOAD, lau_pkg::UNSIGNED_HALFWORD_LOAD, lau_pkg::WORD_LOAD, 3'h3, 3'h5};

  lau_load_unit lau_load_unit_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .instr_valid, .instr,
    .rf_rd_side, .rf_base_idx, .rf_index_idx, .rf_base_data, .rf_index_data, .page_base_a,
    .page_base_b, .base_wb_valid, .base_wb, .dst_we, .dst_wb, .mem_req_valid, .mem_req,
    .mem_rdata);
  lau_partner lau_partner_i (.hclk, .rf_rd_side, .rf_base_idx, .rf_index_idx, .rf_base_data,
    .rf_index_data, .page_base_a, .page_base_b, .mem_req_valid, .mem_req, .mem_rdata);

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic fail(input string m);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask : chk_val

  task automatic chk_pulse(ref lau_exp_t q[$], input logic [37:0] got, input string m);
    lau_exp_t e;
    compares++;
    if (q.size() == 0) begin
      fail({m, " unexpected"});
    end else begin
      e = q.pop_front();
      if (e.c != cyc || e.v !== got) fail($sformatf("%s due %0d got %h exp %h", m, e.c, got, e.v));
    end
  endtask : chk_pulse

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= lau_pkg::HTRANS_NONSEQ;
    haddr  <= 32'(a);
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, $urandom);
    chk_val(rd, e, "register");
    chk_val(32'(hresp), 32'h0, "response");
  endtask : rd_chk

  function automatic logic [31:0] circ_mask(input logic y, input logic [4:0] bi);
    logic [1:0] f;
    logic [4:0] n;
    f = am[{y, bi[1:0], 1'b0} +: 2];
    if (bi < 5'd4 || bi > 5'd7 || f == 2'h0 || f == 2'h3) return 32'hFFFF_FFFF;
    n = (f == lau_pkg::AM_CIRC_BK0) ? am[lau_pkg::AM_BK0_LSB +: 5] : am[lau_pkg::AM_BK1_LSB +: 5];
    return 32'((64'd1 << (int'(n) + 1)) - 64'd1);
  endfunction : circ_mask

  function automatic logic [31:0] ext(input logic [31:0] w, input logic [2:0] ld,
                                      input logic [1:0] a);
    logic [31:0] b8;
    logic [31:0] h16;
    b8  = w >> {a, 3'b000};
    h16 = w >> {a[1], 4'h0};
    case (ld)
      lau_pkg::SIGNED_BYTE_LOAD:       return {{24{b8[7]}}, b8[7:0]};
      lau_pkg::UNSIGNED_BYTE_LOAD:     return 32'(b8[7:0]);
      lau_pkg::SIGNED_HALFWORD_LOAD:   return {{16{h16[15]}}, h16[15:0]};
      lau_pkg::UNSIGNED_HALFWORD_LOAD: return 32'(h16[15:0]);
      default:                         return w;
    endcase
  endfunction : ext

  task automatic gen_one(input logic mis);
    logic [2:0]  ld;
    logic [3:0]  m;
    logic [4:0]  bi, oi, di, c5;
    logic [14:0] c15;
    logic        y, s, lng, bad;
    logic [31:0] b, o, off, mk, sum, nv, a;
    int          sh;
    ld  = mis ? lau_pkg::WORD_LOAD : codes[$urandom % 7];
    bad = ld[0] && (ld != lau_pkg::UNSIGNED_BYTE_LOAD);
    sh  = (ld == lau_pkg::WORD_LOAD) ? 2 : (ld == lau_pkg::SIGNED_HALFWORD_LOAD ||
          ld == lau_pkg::UNSIGNED_HALFWORD_LOAD) ? 1 : 0;
    {y, s, di, c5, c15} = 27'($urandom);
    m   = 4'($urandom);
    if (!m[lau_pkg::MODE_MOD]) m[lau_pkg::MODE_POST] = 1'b0;
    lng = !mis && ($urandom % 4 == 0);
    bi  = ($urandom % 2) ? 5'(4 + $urandom % 4) : 5'($urandom);
    oi  = bi ^ 5'h01;
    b   = ($urandom & 32'hFFFF_FFFC) | 32'(mis);
    o   = $urandom % 64;
    instr_valid <= 1'b1;
    if (lng) begin
      a = b + (32'(c15) << sh);
      lau_partner_i.set_pg(y, b);
      instr <= {4'h0, di, c15, y, ld, lau_pkg::FORM_LONG, s, 1'b0};
    end else begin
      off = (m[lau_pkg::MODE_REG] ? o : 32'(c5)) << sh;
      mk  = circ_mask(y, bi);
      sum = m[lau_pkg::MODE_ADD] ? b + off : b - off;
      nv  = (b & ~mk) | (sum & mk);
      a   = (m[lau_pkg::MODE_MOD] && m[lau_pkg::MODE_POST]) ? b : nv;
      lau_partner_i.set_reg(y, bi, b);
      lau_partner_i.set_reg(y, oi, o);
      instr <= {4'h0, di, bi, m[lau_pkg::MODE_REG] ? oi : c5, m, 1'b0, y, ld,
                lau_pkg::FORM_SHORT, s, 1'b0};
      if (m[lau_pkg::MODE_MOD] && !bad) eq_bwb.push_back('{cyc + 2, 38'({y, bi, nv})});
    end
    if (!bad) begin
      n_loads++;
      last_a = a;
      eq_mem.push_back('{cyc + 2, 38'({lng | y, 2'(sh), a})});
      eq_dst.push_back('{cyc + 6, 38'({s, di, ext(lau_partner_i.mem_word(a), ld, a[1:0])})});
    end
  endtask : gen_one

  task automatic run(input int n, input logic mis, input string nm);
    repeat (n) begin
      @(posedge hclk);
      if (!mis && $urandom % 8 == 0) begin
        instr_valid <= 1'b0;
        instr       <= $urandom;
      end else begin
        gen_one(mis);
      end
    end
    @(posedge hclk);
    instr_valid <= 1'b0;
    repeat (8) @(posedge hclk);
    chk_val(32'(eq_mem.size() + eq_bwb.size() + eq_dst.size()), 32'h0, "pending");
    $display("test %s done", nm);
  endtask : run

  // Every pulse must match the oldest expectation and arrive at its due edge.
  always @(posedge hclk) begin
    if (hresetn === 1'b1) begin
      if (mem_req_valid !== 1'b0) chk_pulse(eq_mem, 38'(mem_req), "mem");
      if (base_wb_valid !== 1'b0) chk_pulse(eq_bwb, 38'(base_wb), "base");
      if (dst_we !== 1'b0) chk_pulse(eq_dst, 38'(dst_wb), "dst");
    end
    cyc <= cyc + 1;
  end

  initial begin
    {hsel, hwrite, instr_valid, hresetn, htrans, haddr, hwdata, instr, am} = '0;
    hsize = 3'h2;
    void'($urandom(45219));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_val(32'({mem_req_valid, base_wb_valid, dst_we}), 32'h0, "reset pulses");
    rd_chk(lau_pkg::OFS_ADDR_MODE, lau_pkg::AM_RST);
    rd_chk(lau_pkg::OFS_STATUS, 32'h0);
    rd_chk(8'h0C, 32'h0);
    $display("test reset done");
    run(150, 1'b0, "linear");
    am = ($urandom & 32'h0000_FFFF) | (32'h2 << lau_pkg::AM_BK0_LSB) |
         (32'h4 << lau_pkg::AM_BK1_LSB);
    ahb(1'b1, lau_pkg::OFS_ADDR_MODE, am | 32'hFC00_0000);
    rd_chk(lau_pkg::OFS_ADDR_MODE, am);
    run(150, 1'b0, "circular");
    rd_chk(lau_pkg::OFS_LAST_ADDR, last_a);
    ahb(1'b1, lau_pkg::OFS_LAST_ADDR, ~last_a);
    rd_chk(lau_pkg::OFS_LAST_ADDR, last_a);
    rd_chk(lau_pkg::OFS_STATUS, 32'(n_loads[15:0]));
    run(1, 1'b1, "misalign");
    rd_chk(lau_pkg::OFS_STATUS, 32'(n_loads[15:0]) | 32'h0100_0000);
    ahb(1'b1, lau_pkg::OFS_STATUS, 32'h0100_0000);
    rd_chk(lau_pkg::OFS_STATUS, 32'(n_loads[15:0]));
    $display("test status done");
    report_and_stop();
  end

  initial begin
    #50000;
    fail("timeout");
    report_and_stop();
  end
endmodule : load_address_unit_bench
`default_nettype wire
